// >>> lsde_decoder.sv
// lsde_decoder: classifies an instruction word and pulls out its fields
// assumes: word is stable while valid is high; purely combinational
`timescale 1ns/1ps
module lsde_decoder
  import lsde_pkg::*;
(
  // instruction
  input wire logic [31:0] instr,
  // decoded
  output lsde_cls_t cls,
  output logic wide,
  output logic [4:0] dst_idx,
  output logic [4:0] src1_idx,
  output logic [4:0] src2_idx,
  output logic [5:0] immr,
  output logic [5:0] imms,
  output logic preferred_lsl
);

  wire var_hit;
  wire unsigned_bitfield_move_hit;
  wire n_bit;
  wire imm32_ok;
  wire imm64_ok;

  // variable shift pattern, left type only
  assign var_hit = (instr[30:21] == LSDE_VAR_FIXED) &&
                   (instr[15:12] == LSDE_VAR_SUBOP) &&
                   (instr[11:10] == LSDE_SHIFT_LEFT);
  // bitfield move pattern
  assign unsigned_bitfield_move_hit = (instr[30:29] == LSDE_UNSIGNED_BITFIELD_MOVE_OPC) &&
                    (instr[28:23] == LSDE_UNSIGNED_BITFIELD_MOVE_FIXED);
  assign n_bit = instr[LSDE_N_BIT];
  assign wide = instr[LSDE_WSEL_BIT];
  assign immr = instr[LSDE_IMMR_LSB +: LSDE_SH_W];
  assign imms = instr[LSDE_IMMS_LSB +: LSDE_SH_W];
  // width/N match and top-bit limits
  assign imm32_ok = !wide && !n_bit && (imms != LSDE_IMMS_ALL32) &&
                    !immr[5] && !imms[5];
  assign imm64_ok = wide && n_bit && (imms != LSDE_IMMS_ALL64);
  // alias preferred when imms + 1 equals immr
  assign preferred_lsl = unsigned_bitfield_move_hit && (imm32_ok || imm64_ok) &&
                         ((imms + 6'h01) == immr);
  // unsigned register indices
  assign dst_idx = instr[LSDE_DST_LSB +: LSDE_IDX_W];
  assign src1_idx = instr[LSDE_SRC1_LSB +: LSDE_IDX_W];
  assign src2_idx = instr[LSDE_SRC2_LSB +: LSDE_IDX_W];
  assign cls = var_hit ? LSDE_CLS_VAR :
               (preferred_lsl ? LSDE_CLS_IMM : LSDE_CLS_NONE);

endmodule

// >>> lsde_pkg.sv
// lsde_pkg: encodings, field positions and reset values for the left-shift unit
// assumes: 32-bit instruction words and 64-bit general-purpose registers
package lsde_pkg;

  // ==========================================================================
  // widths
  localparam int LSDE_XLEN = 64;
  localparam int LSDE_WLEN = 32;
  localparam int LSDE_BASE_SIZE = 32;
  localparam int LSDE_IDX_W = 5;
  localparam int LSDE_SH_W = 6;

  // ==========================================================================
  // field positions
  localparam int LSDE_WSEL_BIT = 31;
  localparam int LSDE_N_BIT = 22;
  localparam int LSDE_SRC2_LSB = 16;
  localparam int LSDE_SRC1_LSB = 5;
  localparam int LSDE_DST_LSB = 0;
  localparam int LSDE_IMMR_LSB = 16;
  localparam int LSDE_IMMS_LSB = 10;

  // ==========================================================================
  // fixed patterns
  localparam logic [9:0] LSDE_VAR_FIXED = 10'h0D6;   // bits 30:21
  localparam logic [3:0] LSDE_VAR_SUBOP = 4'h2;      // bits 15:12
  localparam logic [1:0] LSDE_SHIFT_LEFT = 2'h0;     // bits 11:10
  localparam logic [1:0] LSDE_UNSIGNED_BITFIELD_MOVE_OPC = 2'h2;       // bits 30:29
  localparam logic [5:0] LSDE_UNSIGNED_BITFIELD_MOVE_FIXED = 6'h26;    // bits 28:23
  localparam logic [5:0] LSDE_IMMS_ALL32 = 6'h1F;
  localparam logic [5:0] LSDE_IMMS_ALL64 = 6'h3F;

  // ==========================================================================
  // reset values
  localparam logic [63:0] LSDE_RESULT_RST = 64'h0;
  localparam logic [4:0] LSDE_IDX_RST = 5'h0;

  // ==========================================================================
  // instruction class
  typedef enum logic [2:0] {
    LSDE_CLS_NONE = 3'h1,
    LSDE_CLS_VAR = 3'h2,
    LSDE_CLS_IMM = 3'h4
  } lsde_cls_t;

endpackage

// >>> lsde_regfile.sv
// lsde_regfile: register file model facing the shift unit
// assumes: reads are combinational, writes land on the rising edge
`timescale 1ns/1ps
module lsde_regfile (
  // clock
  input wire logic clk,
  // bench write
  input wire logic we,
  input wire logic [4:0] widx,
  input wire logic [63:0] wdata,
  // read ports
  input wire logic [4:0] ridx1,
  input wire logic [4:0] ridx2,
  output logic [63:0] rdata1,
  output logic [63:0] rdata2,
  // write-back
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [63:0] wb_data
);
  logic [63:0] regs [32];
  // lookup
  assign rdata1 = regs[ridx1];
  assign rdata2 = regs[ridx2];
  // writes, bench first
  always_ff @(posedge clk) begin
    if (we) begin
      regs[widx] <= wdata;
    end else if (wb_valid) begin
      regs[wb_index] <= wb_data;
    end
  end
endmodule

// >>> lsde_shifter.sv
// lsde_shifter: fixed-depth barrel left shifter with zero fill
// assumes: combinational; depth does not depend on the data
`timescale 1ns/1ps
module lsde_shifter
  import lsde_pkg::*;
(
  // operand
  input wire logic [63:0] data_in,
  input wire logic [5:0] amount,
  // result
  output logic [63:0] data_out
);

  logic [63:0] stage [0:6];

  assign stage[0] = data_in;
  // one stage per amount bit, all stages always traversed
  genvar g;
  generate
    for (g = 0; g < LSDE_SH_W; g++) begin : g_stage
      assign stage[g+1] = amount[g] ? {stage[g][63-(2**g):0], {(2**g){1'b0}}} :
                                      stage[g];
    end
  endgenerate
  assign data_out = stage[6];

endmodule

// >>> lsde_top.sv
// lsde_top: decodes and executes logical left shifts, register and immediate forms
// assumes: register file sits outside; operands arrive with the instruction
//
// Overview of operation
// - The variable left-shift encoding is recognised by its fixed bits and shift type zero.
// - Width bit 0 selects a 32-bit datapath and 1 selects 64 bits.
// - The variable distance is the second source value modulo the data size.
// - Vacated low bits fill with zeros and the result goes to the destination index.
// - In 32-bit variable form only the bottom 5 bits of the second source count.
// - In 64-bit variable form only the bottom 6 bits of the second source count.
// - Destination and source indices are unsigned 5-bit fields.
// - The register shift is the variable shift under another name, same encoding.
// - The immediate shift executes as an unsigned bitfield move.
// - The 32-bit immediate form needs width and N zero and imms not 011111.
// - The 64-bit immediate form needs width and N one and imms not 111111.
// - A bitfield move counts as the shift alias only when imms plus one equals immr.
// - Immediate distances are 0 to 31 for 32 bits and 0 to 63 for 64 bits; the code accepts only 1 to 31 and 1 to 63.
// - With data independent timing set, latency ignores operands and flags.
// - Exception handling does not vary with operands or flags.
`timescale 1ns/1ps
module lsde_top
  import lsde_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction from decode stage
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  // operands from register file
  input wire logic [63:0] src1_data,
  input wire logic [63:0] src2_data,
  // processor state
  input wire logic data_independent_timing_bit,
  input wire logic [3:0] condition_flags,
  // register index requests
  output logic [4:0] src1_index,
  output logic [4:0] src2_index,
  output logic insn_accept,
  // write-back
  output logic wb_valid,
  output logic [4:0] wb_index,
  output logic [63:0] wb_data,
  output logic wb_wide,
  output logic wb_is_immediate
);

  lsde_cls_t cls;
  logic wide;
  logic [4:0] dst_idx;
  logic [4:0] s1_idx;
  logic [4:0] s2_idx;
  logic [5:0] immr;
  logic [5:0] imms;
  logic pref;
  logic [63:0] shifted;
  wire is_var;
  wire is_imm;
  wire [63:0] operand;
  wire [5:0] var_amt;
  wire [5:0] imm_amt;
  wire [5:0] amount;
  wire [63:0] next_data;
  wire timing_fixed;
  wire [3:0] flags_unused;

  // ==========================================================================
  // decode
  lsde_decoder u_dec (
    .instr(instr),
    .cls(cls),
    .wide(wide),
    .dst_idx(dst_idx),
    .src1_idx(s1_idx),
    .src2_idx(s2_idx),
    .immr(immr),
    .imms(imms),
    .preferred_lsl(pref)
  );

  // ==========================================================================
  // operand and distance selection
  assign is_var = instr_valid && (cls == LSDE_CLS_VAR);
  assign is_imm = instr_valid && (cls == LSDE_CLS_IMM);
  assign src1_index = s1_idx;
  assign src2_index = s2_idx;
  assign insn_accept = is_var || is_imm;
  // 32-bit form sees only the low half
  assign operand = wide ? src1_data : {32'h0, src1_data[31:0]};
  // modulo data size by masking the low bits
  assign var_amt = wide ? src2_data[5:0] :
                   {1'b0, src2_data[4:0]};
  // shift = 63 - imms or 31 - imms, in range by construction
  assign imm_amt = wide ? (LSDE_IMMS_ALL64 - imms) :
                   (LSDE_IMMS_ALL32 - imms);
  assign amount = is_imm ? imm_amt : var_amt;

  // ==========================================================================
  // execute
  lsde_shifter u_sh (
    .data_in(operand),
    .amount(amount),
    .data_out(shifted)
  );
  // upper half cleared in 32-bit form
  assign next_data = wide ? shifted : {32'h0, shifted[31:0]};
  // latency is one cycle whatever the operands or flags
  assign timing_fixed = data_independent_timing_bit;
  assign flags_unused = condition_flags;

  // ==========================================================================
  // result register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_valid <= 1'b0;
      wb_index <= LSDE_IDX_RST;
      wb_data <= LSDE_RESULT_RST;
      wb_wide <= 1'b0;
      wb_is_immediate <= 1'b0;
    end else begin
      wb_valid <= insn_accept;
      if (insn_accept) begin
        wb_index <= dst_idx;
        wb_data <= next_data;
        wb_wide <= wide;
        wb_is_immediate <= is_imm;
      end
    end
  end

endmodule

// >>> lsde_top_asserts.sv
// lsde_top_asserts: port checks for the left-shift unit
// assumes: bound to lsde_top, one clock, nrst low resets
`timescale 1ns/1ps
module lsde_top_asserts
  import lsde_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // inputs watched
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] src1_data,
  input wire logic [63:0] src2_data,
  // outputs watched
  input wire logic [4:0] src1_index,
  input wire logic [4:0] src2_index,
  input wire logic insn_accept,
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [63:0] wb_data,
  input wire logic wb_wide,
  input wire logic wb_is_immediate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // accepted word and variable form
  wire take = instr_valid && insn_accept;
  wire var_take = take && !instr[30];
  // ==========
  // properties
  property p_ack; take |=> wb_valid; endproperty
  a_ack: assert property (p_ack) else $error("no write-back");
  property p_idle; !take |=> !wb_valid; endproperty
  a_idle: assert property (p_idle) else $error("stray write-back");
  property p_idx; src1_index == instr[9:5] && src2_index == instr[20:16]; endproperty
  a_idx: assert property (p_idx) else $error("source index wrong");
  property p_dst; take |=> wb_index == $past(instr[4:0]); endproperty
  a_dst: assert property (p_dst) else $error("dest index wrong");
  property p_wide; take |=> wb_wide == $past(instr[31]) && wb_is_immediate == $past(instr[30]);
  endproperty
  a_wide: assert property (p_wide) else $error("width or form wrong");
  property p_up; wb_valid && !wb_wide |-> wb_data[63:32] == 32'h0; endproperty
  a_up: assert property (p_up) else $error("upper half not zero");
  property p_v64; var_take && instr[31] |=> wb_data == $past(src1_data) << $past(src2_data[5:0]);
  endproperty
  a_v64: assert property (p_v64) else $error("wide shift wrong");
  property p_v32;
    var_take && !instr[31] |=> wb_data == {32'h0, $past(src1_data[31:0]) << $past(src2_data[4:0])};
  endproperty
  a_v32: assert property (p_v32) else $error("narrow shift wrong");
  property p_op2; instr[30:21] == LSDE_VAR_FIXED && instr[11:10] != 2'h0 |-> !insn_accept;
  endproperty
  a_op2: assert property (p_op2) else $error("other shift taken");
  property p_alias;
    instr[30:23] == 8'hA6 && instr[15:10] + 6'h01 != instr[21:16] |-> !insn_accept;
  endproperty
  a_alias: assert property (p_alias) else $error("non-alias bitfield move taken");
  property p_imm64;
    take && instr[30] && instr[31] |=>
      wb_data == $past(src1_data) << (6'h3F - $past(instr[15:10]));
  endproperty
  a_imm64: assert property (p_imm64) else $error("wide immediate shift wrong");
endmodule
bind lsde_top lsde_top_asserts i_chk (
  .clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
  .src1_data(src1_data), .src2_data(src2_data), .src1_index(src1_index),
  .src2_index(src2_index), .insn_accept(insn_accept), .wb_valid(wb_valid),
  .wb_index(wb_index), .wb_data(wb_data), .wb_wide(wb_wide),
  .wb_is_immediate(wb_is_immediate)
);

// >>> testbench.sv
// testbench: scenarios for the left-shift unit
// assumes: lsde_regfile answers index lookups
`timescale 1ns/1ps
module testbench;
  import lsde_pkg::*;
  logic clk = 0, nrst = 0, instr_valid = 0, dit = 0, we = 0;
  logic [31:0] instr = 0;
  logic [3:0] flags = 0;
  logic [4:0] widx = 0, s1i, s2i, wbi;
  logic [63:0] wdata = 0, s1d, s2d, wbd;
  logic acc, wbv, wbw, wbim;
  int n_fail = 0, checks_done = 0, cyc = 0;
  localparam logic [63:0] SRC = 64'h8123456789ABCDEF;
  lsde_top i_dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .src1_data(s1d), .src2_data(s2d), .data_independent_timing_bit(dit),
    .condition_flags(flags), .src1_index(s1i), .src2_index(s2i), .insn_accept(acc),
    .wb_valid(wbv), .wb_index(wbi), .wb_data(wbd), .wb_wide(wbw), .wb_is_immediate(wbim));
  lsde_regfile i_rf (.clk(clk), .we(we), .widx(widx), .wdata(wdata), .ridx1(s1i),
    .ridx2(s2i), .rdata1(s1d), .rdata2(s2d), .wb_valid(wbv), .wb_index(wbi), .wb_data(wbd));
  // clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end
  // ==========
  // helpers
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(logic [4:0] i, logic [63:0] d);
    @(posedge clk);
    we <= 1;
    widx <= i;
    wdata <= d;
    @(posedge clk);
    we <= 0;
  endtask
  // one word, state bits varied
  task automatic issue(logic [31:0] w, logic ok);
    @(posedge clk);
    instr <= w;
    instr_valid <= 1;
    dit <= ~dit;
    flags <= flags + 4'h5;
    #1 chk("accept", acc, ok);
    @(posedge clk);
    instr_valid <= 0;
    #1 chk("wb_valid", wbv, ok);
  endtask
  // ==========
  // scenarios
  task automatic t_var();
    int amts[5] = '{0, 1, 31, 32, 70};
    logic [6:0] a;
    for (int w = 0; w < 2; w++) begin
      foreach (amts[k]) begin
        a = 7'(amts[k]);
        wreg(2, 64'hA5A5000000000000 | 64'(a));
        issue(32'h1AC22023 | (w << 31), 1);
        chk("var", wbd, w ? SRC << a[5:0] : {32'h0, SRC[31:0] << a[4:0]});
        chk("index", wbi, 3);
        chk("wide", wbw, w);
        chk("reg flag", wbim, 0);
      end
    end
  endtask
  task automatic t_imm();
    int s, sz;
    for (int w = 0; w < 2; w++) begin
      for (int k = 0; k < 2; k++) begin
        sz = 32 << w;
        s = k ? sz - 1 : 1;
        issue(32'h53000023 | (w * 32'h80400000) | ((sz - s) << 16) | ((sz - 1 - s) << 10), 1);
        chk("imm", wbd, w ? SRC << s : {32'h0, SRC[31:0] << s});
        chk("imm flag", wbim, 1);
      end
    end
  endtask
  task automatic t_ref();
    logic [31:0] bad[7] = '{32'h1AC22423, 32'h9AC22823, 32'h53031423, 32'hD3447C23, 32'h0,
      32'h53218023, 32'hD340FC23};
    foreach (bad[k]) begin
      issue(bad[k], 0);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    #1 chk("reset valid", wbv, 0);
    chk("reset data", wbd, LSDE_RESULT_RST);
    chk("reset index", wbi, LSDE_IDX_RST);
    wreg(1, SRC);
    t_var();
    t_imm();
    t_ref();
    conclude();
  end
endmodule
